// ---- pkg/su_pkg.sv ----
// Shared constants and types for the serial unit
package su_pkg;
    // Register addresses
    localparam logic [2:0] ADDR_FRAME_MODE = 3'h0;
    localparam logic [2:0] ADDR_SERIAL_CTRL = 3'h1;
    localparam logic [2:0] ADDR_TX_HOLD = 3'h2;
    localparam logic [2:0] ADDR_FLAGS = 3'h3;
    localparam logic [2:0] ADDR_RX_HOLD = 3'h4;
    localparam logic [2:0] ADDR_RATE_DIV = 3'h5;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h6;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h7;
    // Frame mode register fields
    localparam int FM_SYNC = 7;
    localparam int FM_SEVEN = 6;
    localparam int FM_PARITY = 5;
    localparam int FM_ODD = 4;
    localparam int FM_TWO_STOP = 3;
    localparam int FM_MULTIPROC = 2;
    // Serial control register fields
    localparam int SC_TX_IRQ_EN = 7;
    localparam int SC_RX_IRQ_EN = 6;
    localparam int SC_TX_EN = 5;
    localparam int SC_RX_EN = 4;
    localparam int SC_TXC_IRQ_EN = 2;
    localparam int SC_CLK_HI = 1;
    localparam int SC_CLK_LO = 0;
    // Flag register fields
    localparam int FL_TX_EMPTY = 7;
    localparam int FL_RX_FULL = 6;
    localparam int FL_OVERRUN = 5;
    localparam int FL_FRAMING = 4;
    localparam int FL_PARITY = 3;
    localparam int FL_TX_DONE = 2;
    localparam int FL_RX_MPB = 1;
    localparam int FL_TX_MPB = 0;
    // Interrupt status and mask fields
    localparam int IRQ_RX_FULL = 0;
    localparam int IRQ_RX_ERR = 1;
    localparam int IRQ_TX_EMPTY = 2;
    localparam int IRQ_TX_DONE = 3;
    localparam int IRQ_BREAK = 4;
    localparam int IRQ_W = 5;
    // Reset values
    localparam logic [7:0] FRAME_MODE_RST = 8'h00;
    localparam logic [7:0] SERIAL_CTRL_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h84;
    localparam logic [7:0] RATE_DIV_RST = 8'h00;
    localparam logic [4:0] IRQ_RST = 5'h00;
    // Bit timing on the sixteen-times clock
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_SAMPLE = 4'h7;
    localparam logic [3:0] SYNC_BITS = 4'h8;
    // Clock source codes
    localparam logic [1:0] CLK_INT_PORT = 2'b00;
    localparam logic [1:0] CLK_INT_OUT = 2'b01;
    localparam logic [1:0] CLK_EXT = 2'b10;
    // Receiver states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10
    } su_rx_state_e;
endpackage

// ---- hw/su_rate_div.sv ----
// Programmable divider producing the internal oversampling tick
`timescale 1ns/1ps
`default_nettype none
module su_rate_div #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic run_i,
    input wire logic [W-1:0] div_i,
    output logic tick_o
);
    logic [W-1:0] cnt_ff;

    // Count 0..div, one tick per wrap
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !run_i || cnt_ff == div_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign tick_o = run_i && (cnt_ff == div_i);
endmodule
`default_nettype wire

// ---- hw/su_serial_unit.sv ----
// Serial unit: frame format, clock selection, flags and interrupts
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - async data is seven or eight bits
// - framing, parity, overrun, break reported separately
// - internal async clock from divider, optional output
// - sync frame is eight bits, nothing else
// - sync reception flags overrun only
// - sync clock output internal, input external
// - frame mode bits decode the format
// - clock source bits decode; reserved codes stop
// - good frame fills holding, sets full flag
// - holding to shift load sets empty flag
// - last bit with nothing pending sets done
// - start low, data LSB first, stop high
// - start edge sync, sample eighth tick
// - receive error sets flag, full unchanged
// - parity odd or even, first stop checked
module su_serial_unit (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic tx_line_o,
    input wire logic rx_line_i,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    output logic irq_o
);
    logic [7:0] frame_mode_ff, serial_control_ff, tx_holding_ff, rx_holding_ff;
    logic [7:0] flags_ff, rate_div_ff, rdata_ff;
    logic [4:0] irq_st_ff, irq_mask_ff;
    logic sclk_prev_ff, rx_prev_ff, sclk_ff;
    logic [3:0] bit_sub_ff, rx_sub_ff, rx_cnt_ff, tx_left_ff;
    logic [11:0] tx_shift_ff;
    logic tx_busy_ff;
    logic [9:0] rx_vec_ff;
    su_pkg::su_rx_state_e rx_state_ff;

    logic sync_mode, seven, par_on, mp_on, odd_par, two_stop, ext_clk, clk_valid;
    logic [1:0] clk_sel;
    logic div_tick, tick16, sclk_rise, sclk_fall, sclk_run, sclk_drive;
    logic tx_step, tx_go, tx_last, ev_tx_load, ev_tx_done;
    logic [11:0] frm_bits;
    logic [3:0] frm_len, rx_need;
    logic [7:0] tx_data;
    logic [9:0] rx_word;
    logic [7:0] rx_data;
    logic rx_smp, rx_bit, rx_done, rx_xbit, rx_stop, rx_full, par_exp;
    logic ovr_err, fer_err, per_err, brk_det, ev_rx_ok, ev_rx_err;
    logic [4:0] irq_ev;
    int nb;
    int ext_n;

    assign sync_mode = frame_mode_ff[su_pkg::FM_SYNC];
    assign seven = !sync_mode && frame_mode_ff[su_pkg::FM_SEVEN];
    assign mp_on = !sync_mode && frame_mode_ff[su_pkg::FM_MULTIPROC];
    assign par_on = !sync_mode && frame_mode_ff[su_pkg::FM_PARITY] && !mp_on;
    assign odd_par = frame_mode_ff[su_pkg::FM_ODD];
    assign two_stop = !sync_mode && frame_mode_ff[su_pkg::FM_TWO_STOP];
    assign nb = seven ? 7 : 8;
    assign ext_n = (par_on || mp_on) ? 1 : 0;

    // clock source decode, reserved codes give no clock
    assign clk_sel = {serial_control_ff[su_pkg::SC_CLK_HI], serial_control_ff[su_pkg::SC_CLK_LO]};
    assign ext_clk = (clk_sel == su_pkg::CLK_EXT);
    assign clk_valid = sync_mode ? (clk_sel == su_pkg::CLK_INT_PORT || ext_clk)
                                 : (clk_sel != 2'b11);

    // internal timing from the rate divider
    su_rate_div #(
        .W(8)
    ) u_div (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .run_i(clk_valid && !ext_clk),
        .div_i(rate_div_ff),
        .tick_o(div_tick)
    );

    // Pin is taken as synchronous, so a single stage suffices for edges
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sclk_prev_ff <= 1'b1;
            rx_prev_ff <= 1'b1;
        end else begin
            sclk_prev_ff <= sclk_i;
            rx_prev_ff <= rx_line_i;
        end
    end
    assign sclk_rise = sclk_i && !sclk_prev_ff;
    assign sclk_fall = !sclk_i && sclk_prev_ff;

    // external sixteen-times clock bypasses the divider
    assign tick16 = !clk_valid ? 1'b0 : (ext_clk ? (!sync_mode && sclk_rise) : div_tick);

    // Free-running sub-bit counter for transmit timing and clock out
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            bit_sub_ff <= 4'h0;
        end else if (tick16) begin
            bit_sub_ff <= bit_sub_ff + 4'h1;
        end
    end

    // sync clock is generated internally or taken from the pin
    assign sclk_run = tx_busy_ff || serial_control_ff[su_pkg::SC_RX_EN];
    assign sclk_drive = clk_valid && (sync_mode ? !ext_clk : (clk_sel == su_pkg::CLK_INT_OUT));
    assign sclk_oe_o = sclk_drive;

    // output clock rises at bit centre; idles high when stopped
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sclk_ff <= 1'b1;
        end else begin
            sclk_ff <= (sclk_drive && (!sync_mode || sclk_run)) ? bit_sub_ff[3] : 1'b1;
        end
    end
    assign sclk_o = sclk_ff;

    always_comb begin
        if (!sync_mode) begin
            tx_step = tick16 && (bit_sub_ff == su_pkg::TICK_LAST);
        end else if (ext_clk) begin
            tx_step = clk_valid && sclk_fall;
        end else begin
            tx_step = tick16 && sclk_run && (bit_sub_ff == su_pkg::TICK_LAST);
        end
    end

    // build the outgoing frame, LSB first after a low start
    always_comb begin
        tx_data = seven ? {1'b0, tx_holding_ff[6:0]} : tx_holding_ff;
        frm_bits = 12'hFFF;
        frm_len = su_pkg::SYNC_BITS;
        if (sync_mode) begin
            // sync frame carries only eight data bits
            frm_bits[7:0] = tx_holding_ff;
        end else begin
            frm_bits[0] = 1'b0;
            for (int i = 0; i < 8; i++) begin
                if (i < nb) begin
                    frm_bits[i+1] = tx_data[i];
                end
            end
            if (mp_on) begin
                frm_bits[nb+1] = flags_ff[su_pkg::FL_TX_MPB];
            end else if (par_on) begin
                frm_bits[nb+1] = odd_par ^ (^tx_data);
            end
            frm_len = 4'(2 + nb + ext_n + (two_stop ? 1 : 0));
        end
    end

    assign tx_go = serial_control_ff[su_pkg::SC_TX_EN] && !flags_ff[su_pkg::FL_TX_EMPTY];
    assign tx_last = tx_busy_ff && (tx_left_ff == 4'h1);
    // load from holding when the shift register frees up
    assign ev_tx_load = tx_step && (!tx_busy_ff || tx_last) && tx_go;
    // last bit gone with nothing pending
    assign ev_tx_done = tx_step && tx_last && !tx_go;

    // Transmit shifter; shifting in ones keeps the line at mark when idle
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tx_shift_ff <= 12'hFFF;
            tx_left_ff <= 4'h0;
            tx_busy_ff <= 1'b0;
        end else if (ev_tx_load) begin
            tx_shift_ff <= frm_bits;
            tx_left_ff <= frm_len;
            tx_busy_ff <= 1'b1;
        end else if (tx_step && tx_busy_ff) begin
            tx_shift_ff <= {1'b1, tx_shift_ff[11:1]};
            tx_left_ff <= tx_left_ff - 4'h1;
            tx_busy_ff <= !tx_last;
        end
    end
    assign tx_line_o = tx_shift_ff[0];

    // eighth tick after the start edge lands mid-bit
    assign rx_smp = tick16 && (rx_sub_ff == su_pkg::TICK_SAMPLE);
    assign rx_bit = sync_mode ? (serial_control_ff[su_pkg::SC_RX_EN] &&
                    (ext_clk ? (clk_valid && sclk_rise)
                             : (tick16 && bit_sub_ff == su_pkg::TICK_SAMPLE)))
                  : (rx_state_ff == su_pkg::RX_BITS && rx_smp);
    // only the first stop bit is collected and checked
    assign rx_need = sync_mode ? su_pkg::SYNC_BITS : 4'(nb + ext_n + 1);
    assign rx_done = rx_bit && (rx_cnt_ff == rx_need - 4'h1);

    // Receive state machine
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !serial_control_ff[su_pkg::SC_RX_EN]) begin
            rx_state_ff <= su_pkg::RX_IDLE;
            rx_sub_ff <= 4'h0;
            rx_cnt_ff <= 4'h0;
            rx_vec_ff <= 10'h000;
        end else begin
            if (tick16) begin
                rx_sub_ff <= rx_sub_ff + 4'h1;
            end
            if (rx_bit) begin
                rx_vec_ff <= rx_word;
                rx_cnt_ff <= rx_done ? 4'h0 : rx_cnt_ff + 4'h1;
            end
            unique case (rx_state_ff)
                su_pkg::RX_IDLE: begin
                    if (!sync_mode && clk_valid && rx_prev_ff && !rx_line_i) begin
                        rx_state_ff <= su_pkg::RX_START;
                        rx_sub_ff <= 4'h0;
                    end
                end
                su_pkg::RX_START: begin
                    if (rx_smp) begin
                        rx_state_ff <= rx_line_i ? su_pkg::RX_IDLE : su_pkg::RX_BITS;
                    end
                end
                su_pkg::RX_BITS: begin
                    if (rx_done) begin
                        rx_state_ff <= su_pkg::RX_IDLE;
                    end
                end
                default: begin
                    rx_state_ff <= su_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // Current frame including the bit being sampled now
    always_comb begin
        rx_word = rx_vec_ff;
        rx_word[rx_cnt_ff] = rx_line_i;
    end

    assign rx_data = seven ? {1'b0, rx_word[6:0]} : rx_word[7:0];
    assign rx_xbit = rx_word[nb];
    assign rx_stop = rx_word[nb+ext_n];
    assign rx_full = flags_ff[su_pkg::FL_RX_FULL];
    assign par_exp = odd_par ^ (^rx_data);

    assign ovr_err = rx_full;
    assign fer_err = !sync_mode && !rx_stop;
    assign per_err = par_on && (rx_xbit != par_exp);
    // framing error with every bit low is a break
    assign brk_det = fer_err && (rx_data == 8'h00) && !(ext_n == 1 && rx_xbit);
    assign ev_rx_err = rx_done && (ovr_err || fer_err || per_err);
    assign ev_rx_ok = rx_done && !ev_rx_err;

    // good frame moves to the holding register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_holding_ff <= 8'h00;
        end else if (ev_rx_ok) begin
            rx_holding_ff <= rx_data;
        end
    end

    // Flags: a write of zero clears all but FL_RX_MPB, a hardware event in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            flags_ff <= su_pkg::FLAGS_RST;
        end else begin
            logic [7:0] nxt_flags;
            nxt_flags = flags_ff;
            if (wr_i && addr_i == su_pkg::ADDR_FLAGS) begin
                nxt_flags[7:2] = flags_ff[7:2] & wdata_i[7:2];
                nxt_flags[su_pkg::FL_TX_MPB] = wdata_i[su_pkg::FL_TX_MPB];
            end
            // load sets empty and restarts completion
            if (ev_tx_load) begin
                nxt_flags[su_pkg::FL_TX_EMPTY] = 1'b1;
                nxt_flags[su_pkg::FL_TX_DONE] = 1'b0;
            end
            if (ev_tx_done) begin
                nxt_flags[su_pkg::FL_TX_DONE] = 1'b1;
            end
            if (ev_rx_ok) begin
                nxt_flags[su_pkg::FL_RX_FULL] = 1'b1;
                nxt_flags[su_pkg::FL_RX_MPB] = mp_on && rx_xbit;
            end
            // error flags set, full left alone
            if (rx_done) begin
                nxt_flags[su_pkg::FL_OVERRUN] = nxt_flags[su_pkg::FL_OVERRUN] | ovr_err;
                nxt_flags[su_pkg::FL_FRAMING] = nxt_flags[su_pkg::FL_FRAMING] | fer_err;
                nxt_flags[su_pkg::FL_PARITY] = nxt_flags[su_pkg::FL_PARITY] | per_err;
            end
            flags_ff <= nxt_flags;
        end
    end

    // Interrupt requests need their enables before reaching the status
    assign irq_ev[su_pkg::IRQ_RX_FULL] = ev_rx_ok && serial_control_ff[su_pkg::SC_RX_IRQ_EN];
    assign irq_ev[su_pkg::IRQ_RX_ERR] = ev_rx_err && serial_control_ff[su_pkg::SC_RX_IRQ_EN];
    assign irq_ev[su_pkg::IRQ_TX_EMPTY] = ev_tx_load && serial_control_ff[su_pkg::SC_TX_IRQ_EN];
    assign irq_ev[su_pkg::IRQ_TX_DONE] = ev_tx_done && serial_control_ff[su_pkg::SC_TXC_IRQ_EN];
    assign irq_ev[su_pkg::IRQ_BREAK] = rx_done && brk_det &&
                                       serial_control_ff[su_pkg::SC_RX_IRQ_EN];

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_st_ff <= su_pkg::IRQ_RST;
        end else if (wr_i && addr_i == su_pkg::ADDR_IRQ_STATUS) begin
            irq_st_ff <= (irq_st_ff & ~wdata_i[4:0]) | irq_ev;
        end else begin
            irq_st_ff <= irq_st_ff | irq_ev;
        end
    end
    assign irq_o = |(irq_st_ff & irq_mask_ff);

    // Software-written configuration registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            frame_mode_ff <= su_pkg::FRAME_MODE_RST;
            serial_control_ff <= su_pkg::SERIAL_CTRL_RST;
            tx_holding_ff <= 8'h00;
            rate_div_ff <= su_pkg::RATE_DIV_RST;
            irq_mask_ff <= su_pkg::IRQ_RST;
        end else if (wr_i) begin
            unique case (addr_i)
                su_pkg::ADDR_FRAME_MODE: frame_mode_ff <= wdata_i;
                su_pkg::ADDR_SERIAL_CTRL: serial_control_ff <= wdata_i;
                su_pkg::ADDR_TX_HOLD: tx_holding_ff <= wdata_i;
                su_pkg::ADDR_RATE_DIV: rate_div_ff <= wdata_i;
                su_pkg::ADDR_IRQ_MASK: irq_mask_ff <= wdata_i[4:0];
                default: begin
                end
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !rd_i) begin
            rdata_ff <= 8'h00;
        end else begin
            unique case (addr_i)
                su_pkg::ADDR_FRAME_MODE: rdata_ff <= frame_mode_ff;
                su_pkg::ADDR_SERIAL_CTRL: rdata_ff <= serial_control_ff;
                su_pkg::ADDR_TX_HOLD: rdata_ff <= tx_holding_ff;
                su_pkg::ADDR_FLAGS: rdata_ff <= flags_ff;
                su_pkg::ADDR_RX_HOLD: rdata_ff <= rx_holding_ff;
                su_pkg::ADDR_RATE_DIV: rdata_ff <= rate_div_ff;
                su_pkg::ADDR_IRQ_STATUS: rdata_ff <= {3'h0, irq_st_ff};
                su_pkg::ADDR_IRQ_MASK: rdata_ff <= {3'h0, irq_mask_ff};
            endcase
        end
    end
    assign rdata_o = rdata_ff;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    seven_len_a: assert property (
        ev_tx_load && seven && ext_n == 0 && !two_stop |=> tx_left_ff == 4'h9)
        else $error("seven-bit frame length wrong");
    framing_flag_a: assert property (
        rx_done && fer_err |=> flags_ff[su_pkg::FL_FRAMING])
        else $error("framing error not flagged");
    clk_phase_a: assert property (
        !sync_mode && sclk_drive && tick16 && bit_sub_ff == 4'h7 |=> ##1 sclk_o)
        else $error("output clock not high after bit centre");
    ext_bypass_a: assert property (
        !sync_mode && ext_clk && !sclk_rise |-> !tick16)
        else $error("tick without external edge");
    sync_len_a: assert property (
        ev_tx_load && sync_mode |=> tx_left_ff == 4'h8 && tx_line_o == $past(tx_holding_ff[0]))
        else $error("sync frame not eight plain bits");
    sync_err_a: assert property (
        sync_mode && rx_done |=> !$rose(flags_ff[su_pkg::FL_FRAMING]) &&
            !$rose(flags_ff[su_pkg::FL_PARITY]))
        else $error("sync mode raised framing or parity");
    sync_step_a: assert property (
        sync_mode && ext_clk && clk_valid && sclk_fall && tx_busy_ff && !tx_last
        |=> tx_left_ff == $past(tx_left_ff) - 4'h1)
        else $error("sync external edge did not shift");
    rx_full_a: assert property (
        ev_rx_ok |=> rx_full && rx_holding_ff == $past(rx_data))
        else $error("good frame not stored");
    tx_empty_a: assert property (
        ev_tx_load |=> flags_ff[su_pkg::FL_TX_EMPTY] && tx_busy_ff)
        else $error("load did not set empty");
    tx_done_a: assert property (
        ev_tx_done |=> flags_ff[su_pkg::FL_TX_DONE] && !tx_busy_ff && tx_line_o)
        else $error("completion not flagged");
    start_bit_a: assert property (
        ev_tx_load && !sync_mode |=> !tx_line_o)
        else $error("frame did not begin low");
    false_start_a: assert property (
        rx_state_ff == su_pkg::RX_START && rx_smp && rx_line_i |=> rx_state_ff == su_pkg::RX_IDLE)
        else $error("false start not rejected");
    err_keep_a: assert property (
        ev_rx_err && !(wr_i && addr_i == su_pkg::ADDR_FLAGS)
        |=> rx_full == $past(rx_full) && rx_holding_ff == $past(rx_holding_ff))
        else $error("error frame touched full flag");
    parity_chk_a: assert property (
        rx_done && par_on && rx_xbit != par_exp |=> flags_ff[su_pkg::FL_PARITY])
        else $error("parity error missed");
    break_a: assert property (
        rx_done && brk_det && serial_control_ff[su_pkg::SC_RX_IRQ_EN]
        |=> irq_st_ff[su_pkg::IRQ_BREAK])
        else $error("break not reported");
endmodule
`default_nettype wire

// ---- tb/su_peer.sv ----
// Remote serial peer: sends and captures asynchronous frames
`timescale 1ns/1ps
`default_nettype none
module su_peer (
    input wire logic clk_i,
    input wire logic tx_line_i,
    output logic rx_line_o,
    output logic sclk_o
);
    // Line and clock pin idle high between frames
    initial rx_line_o = 1'b1;
    initial sclk_o = 1'b1;
    task automatic send(input logic [9:0] bits);
        for (int i = 0; i < 10; i++) begin
            rx_line_o <= bits[i];
            repeat (16) @(posedge clk_i);
        end
        rx_line_o <= 1'b1;
    endtask
    // peer supplies sixteen clock periods per bit
    task automatic send_ext(input logic [9:0] bits);
        for (int i = 0; i < 10; i++) begin
            rx_line_o <= bits[i];
            repeat (16) begin
                sclk_o <= 1'b0;
                @(posedge clk_i);
                sclk_o <= 1'b1;
                @(posedge clk_i);
            end
        end
        rx_line_o <= 1'b1;
    endtask
    // peer clocks a sync frame, captures after each fall
    task automatic clock_sync(output logic [7:0] b);
        for (int i = 0; i < 9; i++) begin
            sclk_o <= 1'b0;
            repeat (2) @(posedge clk_i);
            if (i < 8) begin
                b[i] = tx_line_i;
            end
            sclk_o <= 1'b1;
            repeat (2) @(posedge clk_i);
        end
    endtask
    // sample mid bit; polled on the falling edge to stay clear of updates
    task automatic recv(output logic [9:0] bits);
        int t;
        bits = 'x;
        for (t = 0; t < 400 && tx_line_i !== 1'b0; t++) @(negedge clk_i);
        if (t < 400) begin
            repeat (8) @(negedge clk_i);
            for (int i = 0; i < 10; i++) begin
                bits[i] = tx_line_i;
                repeat (16) @(negedge clk_i);
            end
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Bench for the serial unit: registers, framing, flags and interrupts
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic tx_line_o, rx_line, sclk, sclk_o, sclk_oe_o, irq_o;
    logic [7:0] v;
    logic [9:0] f;
    int fail_count = 0;
    int checks = 0;
    // Period of 100 ns
    always #50 clk_i = ~clk_i;
    // Clock pin input comes from the peer, which idles it high
    su_serial_unit dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .tx_line_o(tx_line_o), .rx_line_i(rx_line), .sclk_i(sclk), .sclk_o(sclk_o),
        .sclk_oe_o(sclk_oe_o), .irq_o(irq_o));
    su_peer peer_u (.clk_i(clk_i), .tx_line_i(tx_line_o), .rx_line_o(rx_line),
        .sclk_o(sclk));
    // Compare and count
    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic test_tx();
        int t;
        rd(su_pkg::ADDR_FLAGS, v);
        chk("flags after reset", v, 8'h84);
        chk("clock pin enable", sclk_oe_o, 1'b0);
        wr(su_pkg::ADDR_IRQ_MASK, 8'h08);
        wr(su_pkg::ADDR_SERIAL_CTRL, 8'hA5);
        // holding written first, then empty flag cleared
        wr(su_pkg::ADDR_TX_HOLD, 8'h3C);
        wr(su_pkg::ADDR_FLAGS, 8'h7B);
        chk("clock output enable", sclk_oe_o, 1'b1);
        peer_u.recv(f);
        chk("tx frame", f, {1'b1, 8'h3C, 1'b0});
        // Completion must follow the stop bit within a bounded wait
        for (t = 0; t < 60; t++) begin
            rd(su_pkg::ADDR_FLAGS, v);
            if (v[su_pkg::FL_TX_DONE] === 1'b1) break;
        end
        chk("tx done", v[su_pkg::FL_TX_DONE], 1'b1);
        if (t == 60) stop_test();
        rd(su_pkg::ADDR_IRQ_STATUS, v);
        chk("irq status tx", v, 8'h0C);
        chk("irq unmasked", irq_o, 1'b1);
        wr(su_pkg::ADDR_IRQ_STATUS, 8'h08);
        @(negedge clk_i);
        chk("irq masked", irq_o, 1'b0);
    endtask
    task automatic test_rx();
        wr(su_pkg::ADDR_SERIAL_CTRL, 8'h50);
        wr(su_pkg::ADDR_IRQ_STATUS, 8'h1F);
        peer_u.send({1'b1, 8'h96, 1'b0});
        rd(su_pkg::ADDR_FLAGS, v);
        chk("rx full", v[su_pkg::FL_RX_FULL], 1'b1);
        rd(su_pkg::ADDR_RX_HOLD, v);
        chk("rx data", v, 8'h96);
        // Second frame without emptying the holding register
        peer_u.send({1'b1, 8'h11, 1'b0});
        rd(su_pkg::ADDR_FLAGS, v);
        chk("overrun", v[6:5], 2'b11);
        rd(su_pkg::ADDR_RX_HOLD, v);
        chk("rx data kept", v, 8'h96);
        rd(su_pkg::ADDR_IRQ_STATUS, v);
        chk("irq status rx", v, 8'h03);
    endtask
    task automatic test_err();
        wr(su_pkg::ADDR_FLAGS, 8'h9F);
        wr(su_pkg::ADDR_IRQ_STATUS, 8'h1F);
        wr(su_pkg::ADDR_FRAME_MODE, 8'h60);
        peer_u.send({1'b1, 1'b0, 7'h55, 1'b0});
        rd(su_pkg::ADDR_RX_HOLD, v);
        chk("seven bit data", v, 8'h55);
        // holding read, full flag cleared before next frame
        wr(su_pkg::ADDR_FLAGS, 8'hBF);
        peer_u.send({1'b1, 1'b1, 7'h55, 1'b0});
        rd(su_pkg::ADDR_FLAGS, v);
        chk("parity error", v[6:3], 4'b0001);
        wr(su_pkg::ADDR_FLAGS, 8'hF7);
        wr(su_pkg::ADDR_FRAME_MODE, 8'h00);
        wr(su_pkg::ADDR_IRQ_STATUS, 8'h1F);
        peer_u.send(10'h000);
        rd(su_pkg::ADDR_FLAGS, v);
        chk("framing error", v[6:3], 4'b0010);
        rd(su_pkg::ADDR_IRQ_STATUS, v);
        chk("break event", v, 8'h12);
        wr(su_pkg::ADDR_FRAME_MODE, 8'h80);
        wr(su_pkg::ADDR_SERIAL_CTRL, 8'h00);
        chk("sync clock output", sclk_oe_o, 1'b1);
    endtask
    // External clock: async odd-parity reception, then a sync transmit
    task automatic test_ext();
        wr(su_pkg::ADDR_FLAGS, 8'h87);
        wr(su_pkg::ADDR_FRAME_MODE, 8'h70);
        wr(su_pkg::ADDR_SERIAL_CTRL, 8'h12);
        chk("ext clock pin input", sclk_oe_o, 1'b0);
        peer_u.send_ext({1'b1, 1'b1, 7'h0F, 1'b0});
        rd(su_pkg::ADDR_FLAGS, v);
        chk("ext rx flags", v[6:3], 4'b1000);
        rd(su_pkg::ADDR_RX_HOLD, v);
        chk("ext rx data", v, 8'h0F);
        chk("ext clock out idle", sclk_o, 1'b1);
        wr(su_pkg::ADDR_FRAME_MODE, 8'h80);
        wr(su_pkg::ADDR_SERIAL_CTRL, 8'h22);
        wr(su_pkg::ADDR_TX_HOLD, 8'hA5);
        wr(su_pkg::ADDR_FLAGS, 8'h7B);
        peer_u.clock_sync(v);
        chk("sync ext tx", v, 8'hA5);
        rd(su_pkg::ADDR_FLAGS, v);
        chk("sync ext empty", v[su_pkg::FL_TX_EMPTY], 1'b1);
        chk("sync ext done", v[su_pkg::FL_TX_DONE], 1'b1);
    endtask
    // Reset for five cycles, then the scenarios in turn
    initial begin
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        test_tx();
        test_rx();
        test_err();
        test_ext();
        stop_test();
    end
endmodule
`default_nettype wire
